// ===== rtl/aipc_input_path.sv
// input path control: registers, mic decode, filter, volume, routing
// How it works
// - four channels, pair source, per-channel routing
// - channel may take rate converter samples
// - shared pin drives exactly one function
// - gain amp path inverts sample sign
// - four gain registers with enable bit
// - per-channel boost adds fixed gain step
// - precharge default on, off when amp on
// - two bias outputs, enable and level
// - swap bit exchanges pair left/right
// - polarity bit negates mic samples
// - clock output pin clocks microphones
// - mic streams go straight to decimation
// - each pair uses exactly one source
// - signed samples at 192 or 96 kHz
// - overrange clips, never wraps
// - volume attenuates in 0.375 dB steps
// - mute silences converter and mic channels regardless of volume, not rate converter ones
// - switchable dc block, three corners
//
// The plain strobed port was chosen for this implementation.
module aipc_input_path import aipc_pkg::*; #(
  parameter int CLK_HALF = 4,   // mclk cycles per half clock out
  parameter int DECIM = 64      // mic bits per sample at 96 kHz
) (
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   reset,
  // register port
  input  wire logic [7:0]             regAddr,
  input  wire logic [7:0]             regWdata,
  input  wire logic                   regWr,
  input  wire logic                   regRd,
  output logic      [7:0]             regRdata,
  // converter and rate converter samples
  input  wire logic [3:0][23:0]       adcSample,
  input  wire logic [3:0]             adcValid,
  input  wire logic [1:0][23:0]       asrcSample,
  input  wire logic                   asrcValid,
  // microphone link
  input  wire logic                   micPairAPin,
  input  wire logic                   micPairBPin,
  output logic                        clockOutputPin,
  // shared output pin sources and pin
  input  wire logic                   serialOutDataFirst,
  input  wire logic                   densityStreamBit,
  output logic                        sharedOutPin,
  // analog controls
  input  wire logic [1:0]             hpEnable,
  output logic [5:0]                  prechargeOn,
  output logic [3:0]                  gainAmpEnable,
  output logic [3:0]                  gainAmpBoost,
  output logic [3:0][5:0]             gainAmpGain,
  output logic [1:0]                  micBiasEnable,
  output logic [1:0]                  micBiasHigh,
  output logic                        rate96,
  // core side
  output logic [3:0][23:0]            coreSample,
  output logic [3:0]                  coreValid
);

  typedef struct packed {
    logic [15:0][7:0] regs;        // control registers
    logic [7:0]       rdata;       // read answer
    logic [1:0][2:0]  sync;        // pin synchronisers
    logic [1:0]       micLvl;      // filtered pin levels
    logic [7:0]       divCnt;      // clock out divider
    logic             clock_output_pin;      // clock out level
    logic [7:0]       bitCnt;      // bits in current window
    logic [3:0][7:0]  ones;        // ones per mic channel
    logic [3:0][23:0] micSample;   // decoded mic samples
    logic             micValid;    // decoded sample strobe
    logic [3:0][39:0] dc;          // dc estimate, 16 fraction bits
    logic [3:0][23:0] coreSample;  // core samples
    logic [3:0]       coreValid;   // core strobes
    logic             sharedPin;   // shared pin level
    logic [5:0]       precharge;   // precharge amp enables
  } aipc_state_t;

  aipc_state_t st_reg, st_next;

  // clip a wide value to the 24-bit range
  function automatic logic [23:0] sat24(input logic signed [41:0] v);
    if (v > 42'sh7FFFFF) sat24 = 24'h7FFFFF;
    else if (v < -42'sh800000) sat24 = 24'h800000;
    else sat24 = v[23:0];
  endfunction

  // attenuate by code x 0.375 dB: fine table then whole 6 dB shifts
  function automatic logic [23:0] vol(input logic [23:0] x,
                                       input logic [7:0] code);
    logic signed [40:0] p;
    p = $signed(x) * $signed({1'b0, VOL_COEF[code[3:0]]});
    p = p >>> (15 + code[7:4]);
    vol = p[23:0];
  endfunction

  // map a byte address to a register slot
  function automatic logic [4:0] slot(input logic [7:0] a);
    if (a >= OFF_CTL0 && a <= OFF_GAIN3) slot = {1'b1, 4'(a - OFF_CTL0)};
    else if (a == OFF_POP) slot = {1'b1, 4'(IX_POP)};
    else if (a == OFF_BIAS) slot = {1'b1, 4'(IX_BIAS)};
    else if (a == OFF_PINA) slot = {1'b1, 4'(IX_PINA)};
    else if (a == OFF_PINB) slot = {1'b1, 4'(IX_PINB)};
    else slot = 5'h00;
  endfunction

  // shared working values
  logic [4:0]  hit;
  logic        wrap;
  logic        tap;
  logic [7:0]  win;
  logic [1:0]  micOn;
  logic        r96;

  // next state
  always_comb begin
    logic signed [41:0] x;
    logic signed [41:0] d;
    logic [23:0] s;
    logic [23:0] y;
    logic        v;
    int          k;
    int          sw;
    x = '0;
    d = '0;
    s = '0;
    y = '0;
    v = 1'b0;
    k = 0;
    sw = 0;
    st_next = st_reg;
    r96 = st_reg.regs[IX_CTL][CTL_RATE];
    // register port, reads answered in the next cycle
    hit = slot(regAddr);
    if (regWr && hit[4]) begin
      st_next.regs[hit[3:0]] = regWdata & REG_MASK[hit[3:0]];
    end
    st_next.rdata = 8'h00;
    if (regRd && hit[4]) begin
      st_next.rdata = st_reg.regs[hit[3:0]];
    end
    // precharge stays on until disabled or its amplifier is on
    for (int i = 0; i < 4; i++) begin
      st_next.precharge[i] = !st_reg.regs[IX_POP][i] &&
                             !st_reg.regs[IX_GAIN+i][GA_EN];
    end
    for (int i = 0; i < 2; i++) begin
      st_next.precharge[4+i] = !st_reg.regs[IX_POP][4+i] &&
                               !hpEnable[i];
    end
    // only one function reaches the shared pin
    st_next.sharedPin = st_reg.regs[IX_CTL+1][CTL_SHARE] ?
                        densityStreamBit : serialOutDataFirst;
    // pins pass three flops, a level counts once stages two and three agree
    st_next.sync[0] = {st_reg.sync[0][1:0], micPairAPin};
    st_next.sync[1] = {st_reg.sync[1][1:0], micPairBPin};
    for (int p = 0; p < 2; p++) begin
      if (st_reg.sync[p][1] == st_reg.sync[p][2]) begin
        st_next.micLvl[p] = st_reg.sync[p][2];
      end
    end
    // clock out: free divider of mclk, the only mic clock
    wrap = st_reg.divCnt == 8'(CLK_HALF - 1);
    st_next.divCnt = wrap ? 8'h00 : st_reg.divCnt + 8'h01;
    if (wrap) begin
      st_next.clock_output_pin = !st_reg.clock_output_pin;
    end
    // pair active only with enable bit and mic pin mode
    micOn[0] = st_reg.regs[IX_CTL+2][CTL_MICEN] &&
               st_reg.regs[IX_PINA][3:0] == PIN_MODE_MIC;
    micOn[1] = st_reg.regs[IX_CTL+3][CTL_MICEN] &&
               st_reg.regs[IX_PINB][3:0] == PIN_MODE_MIC;
    // decimation window shortens at the higher rate
    win = r96 ? 8'(DECIM) : 8'(DECIM / 2);
    st_next.micValid = 1'b0;
    // the filtered level trails the pin by SYNC_DLY cycles, so a bit is
    // counted that long after its clock edge; needs CLK_HALF >= SYNC_DLY
    tap = st_reg.divCnt == 8'(SYNC_DLY - 1);
    // left bit stood at the falling edge, right bit at the rising edge
    if (tap && !st_reg.clock_output_pin) begin
      for (int p = 0; p < 2; p++) begin
        st_next.ones[2*p] = st_reg.ones[2*p] + 8'(st_reg.micLvl[p]);
      end
    end
    if (tap && st_reg.clock_output_pin) begin
      for (int p = 0; p < 2; p++) begin
        st_next.ones[2*p+1] = st_reg.ones[2*p+1] + 8'(st_reg.micLvl[p]);
      end
      st_next.bitCnt = st_reg.bitCnt + 8'h01;
      // a rate change mid-window closes it early rather than wrapping
      if (st_reg.bitCnt >= win - 8'h01) begin
        // window closes: bit density straight to samples
        st_next.bitCnt = 8'h00;
        st_next.micValid = 1'b1;
        for (int c = 0; c < 4; c++) begin
          sw = (c % 2 == 1) ? 1 : 0;
          // swap exchanges the pair before filtering
          if (st_reg.regs[IX_CTL+2+c/2][CTL_SWAP]) begin
            sw = 1 - sw;
          end
          x = 42'(st_next.ones[2*(c/2)+sw]);
          x = (2 * x - 42'(win)) <<< (r96 ? 17 : 18);
          // polarity bit negates the decoded sample
          if (st_reg.regs[IX_PINA+c/2][PIN_POL_EVEN+c%2]) begin
            x = -x;
          end
          st_next.micSample[c] = sat24(x);
          st_next.ones[2*(c/2)+sw] = 8'h00;
        end
      end
    end
    // per channel source select, filter, volume, mute, routing
    for (int c = 0; c < 4; c++) begin
      if (st_reg.regs[IX_CTL+c][CTL_RATE_CONVERTER]) begin
        // rate converter bypasses the converter chain
        y = asrcSample[c%2];
        v = asrcValid;
      end else begin
        if (micOn[c/2]) begin
          // a pair takes one source only
          x = 42'($signed(st_reg.micSample[c]));
          v = st_reg.micValid;
        end else begin
          x = 42'($signed(adcSample[c]));
          v = adcValid[c];
          // gain amp path arrives inverted
          if (st_reg.regs[IX_GAIN+c][GA_EN]) begin
            x = -x;
          end
        end
        s = sat24(x);
        // dc block: subtract a slowly tracking estimate
        case (st_reg.regs[IX_CTL+c][CTL_CORNER+:2])
          2'h0:    k = HPF_K_1HZ;
          2'h1:    k = HPF_K_4HZ;
          default: k = HPF_K_8HZ;
        endcase
        if (r96) begin
          k = k - 1;
        end
        if (st_reg.regs[IX_CTL+c][CTL_HPF]) begin
          d = 42'($signed(s)) - 42'($signed(st_reg.dc[c][39:16]));
          s = sat24(d);
          if (v) begin
            d = {{2{s[23]}}, s, 16'h0000} - 42'($signed(st_reg.dc[c]));
            st_next.dc[c] = 40'(42'($signed(st_reg.dc[c])) + (d >>> k));
          end
        end else begin
          st_next.dc[c] = 40'h0;
        end
        y = vol(s, st_reg.regs[IX_VOL+c]);
        // mute forces zero whatever the volume
        if (st_reg.regs[IX_CTL+c][CTL_MUTE]) begin
          y = 24'h000000;
        end
      end
      st_next.coreValid[c] = v && st_reg.regs[IX_CTL+c][CTL_ROUTE];
      if (st_next.coreValid[c]) begin
        st_next.coreSample[c] = y;
      end
    end
  end

  // state register
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state flops
  assign regRdata = st_reg.rdata;
  assign clockOutputPin = st_reg.clock_output_pin;
  assign sharedOutPin = st_reg.sharedPin;
  assign prechargeOn = st_reg.precharge;
  assign rate96 = st_reg.regs[IX_CTL][CTL_RATE];
  assign coreSample = st_reg.coreSample;
  assign coreValid = st_reg.coreValid;
  assign micBiasEnable = {st_reg.regs[IX_BIAS][BIAS_EN_B],
                          st_reg.regs[IX_BIAS][BIAS_EN_A]};
  assign micBiasHigh = {st_reg.regs[IX_BIAS][BIAS_HI_B],
                        st_reg.regs[IX_BIAS][BIAS_HI_A]};
  // gain amp fields per channel, boost adds the fixed step
  for (genvar g = 0; g < 4; g++) begin : g_gain
    assign gainAmpEnable[g] = st_reg.regs[IX_GAIN+g][GA_EN];
    assign gainAmpBoost[g] = st_reg.regs[IX_GAIN+g][GA_BOOST];
    assign gainAmpGain[g] = st_reg.regs[IX_GAIN+g][5:0];
  end

  // checks
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  logic plainAdc0;  // channel 0 on converter, no filter, routed, unmuted
  assign plainAdc0 = st_reg.regs[IX_CTL][5:0] == 6'h10 && !micOn[0];

  property p_precharge_off;
    st_reg.regs[IX_GAIN][GA_EN] |=> !prechargeOn[0];
  endproperty
  a_precharge_off: assert property (p_precharge_off)
    else $error("precharge on while gain amp enabled");

  property p_mute_zero;
    st_reg.regs[IX_CTL][CTL_MUTE] && st_reg.regs[IX_CTL][CTL_ROUTE] &&
    !st_reg.regs[IX_CTL][CTL_RATE_CONVERTER] && !micOn[0] && adcValid[0]
    |=> coreValid[0] && coreSample[0] == 24'h000000;
  endproperty
  a_mute_zero: assert property (p_mute_zero)
    else $error("muted channel gave nonzero sample");

  property p_readback;
    logic [7:0] a, w;
    (regWr, a = regAddr, w = regWdata) ##1 !regWr ##1 (regRd &&
      regAddr == a && slot(a) != 5'h00 && !regWr)
    |=> regRdata == (w & REG_MASK[4'(slot(a))]);
  endproperty
  a_readback: assert property (p_readback)
    else $error("register read back differs from write");

  property p_shared_pin;
    st_reg.regs[IX_CTL+1][CTL_SHARE]
    |=> sharedOutPin == $past(densityStreamBit);
  endproperty
  a_shared_pin: assert property (p_shared_pin)
    else $error("shared pin not carrying density stream");

  property p_bias;
    regWr && regAddr == OFF_BIAS |=> micBiasEnable[1] == $past(regWdata[2])
      && micBiasHigh[0] == $past(regWdata[1]);
  endproperty
  a_bias: assert property (p_bias)
    else $error("bias outputs do not follow write");

  property p_invert_clip;
    plainAdc0 && st_reg.regs[IX_GAIN][GA_EN] && st_reg.regs[IX_VOL] == 8'h00
      && adcValid[0]
    |=> coreValid[0] &&
        coreSample[0] == sat24(-42'($signed($past(adcSample[0]))));
  endproperty
  a_invert_clip: assert property (p_invert_clip)
    else $error("gain amp path not inverted and clipped");

  property p_volume_half;
    plainAdc0 && !st_reg.regs[IX_GAIN][GA_EN] && st_reg.regs[IX_VOL] == 8'h10
      && adcValid[0]
    |=> coreSample[0] == 24'($signed($past(adcSample[0])) >>> 1);
  endproperty
  a_volume_half: assert property (p_volume_half)
    else $error("16 volume steps did not give half amplitude");

  property p_clk_out;
    $changed(clockOutputPin) |=> !$changed(clockOutputPin) [*3];
  endproperty
  a_clk_out: assert property (p_clk_out)
    else $error("clock out half period wrong");

  property p_one_source;
    micOn[0] && !st_reg.regs[IX_CTL][CTL_RATE_CONVERTER] && adcValid[0] &&
      !st_reg.micValid |=> !coreValid[0];
  endproperty
  a_one_source: assert property (p_one_source)
    else $error("converter sample passed on a mic pair");

  // a closed window reaches a routed mic channel in the next cycle
  property p_mic_route;
    micOn[0] && st_reg.micValid && st_reg.regs[IX_CTL][CTL_ROUTE] &&
      !st_reg.regs[IX_CTL][CTL_RATE_CONVERTER] |=> coreValid[0];
  endproperty
  a_mic_route: assert property (p_mic_route)
    else $error("mic window did not reach the core");

  c_mic_sample: cover property (st_reg.micValid && micOn[0]);
  c_mic_swap: cover property (st_reg.micValid && micOn[0] &&
                              st_reg.regs[IX_CTL+2][CTL_SWAP]);
  c_rate_converter_route: cover property (asrcValid && st_reg.regs[IX_CTL][CTL_RATE_CONVERTER]
                                ##1 coreValid[0]);
  c_hpf_run: cover property (st_reg.regs[IX_CTL][CTL_HPF] ##1 coreValid[0]);
endmodule

// ===== rtl/aipc_pkg.sv
// package: register map, field layout and constants of the input path
package aipc_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTL0   = 8'h1B;  // input_control_0..3
  localparam logic [7:0] OFF_CTL3   = 8'h1E;
  localparam logic [7:0] OFF_VOL0   = 8'h1F;  // input_volume_0..3
  localparam logic [7:0] OFF_VOL3   = 8'h22;
  localparam logic [7:0] OFF_GAIN0  = 8'h23;  // gain_amp_setting_0..3
  localparam logic [7:0] OFF_GAIN3  = 8'h26;
  localparam logic [7:0] OFF_POP    = 8'h29;  // pop_suppression
  localparam logic [7:0] OFF_BIAS   = 8'h2D;  // mic_bias_control
  localparam logic [7:0] OFF_PINA   = 8'h3C;  // pin_mode_mic_pair_a
  localparam logic [7:0] OFF_PINB   = 8'h3D;  // pin_mode_mic_pair_b
  // register file slots
  localparam int IX_CTL = 0;
  localparam int IX_VOL = 4;
  localparam int IX_GAIN = 8;
  localparam int IX_POP = 12;
  localparam int IX_BIAS = 13;
  localparam int IX_PINA = 14;
  localparam int IX_PINB = 15;
  // input_control fields
  localparam int CTL_MUTE = 0;    // digital mute
  localparam int CTL_HPF = 1;     // dc block filter enable
  localparam int CTL_CORNER = 2;  // [3:2] corner: 0=1Hz 1=4Hz 2,3=8Hz
  localparam int CTL_ROUTE = 4;   // channel feeds the core
  localparam int CTL_RATE_CONVERTER = 5;    // take rate_converter instead
  localparam int CTL_MICEN = 6;   // ctl2/ctl3: mic pair a/b enable
  localparam int CTL_SWAP = 7;    // ctl2/ctl3: mic pair a/b swap
  localparam int CTL_RATE = 7;    // ctl0: 1 = 96 kHz, 0 = 192 kHz
  localparam int CTL_SHARE = 7;   // ctl1: 1 = density stream on pin
  // gain_amp_setting fields
  localparam int GA_EN = 7;
  localparam int GA_BOOST = 6;
  // mic_bias_control fields
  localparam int BIAS_EN_A = 0;
  localparam int BIAS_HI_A = 1;   // 1 = 0.90 x supply, 0 = 0.65
  localparam int BIAS_EN_B = 2;
  localparam int BIAS_HI_B = 3;
  // pin mode fields
  localparam logic [3:0] PIN_MODE_MIC = 4'h1;
  localparam int PIN_POL_EVEN = 4;  // invert even channel of pair
  localparam int PIN_POL_ODD = 5;   // invert odd channel of pair
  // mclk cycles from a pin change to the filtered mic level
  localparam int SYNC_DLY = 4;
  // writable bits per slot, reserved bits read zero
  localparam logic [15:0][7:0] REG_MASK = {
    8'h3F, 8'h3F, 8'h0F, 8'h3F, {4{8'hFF}}, {4{8'hFF}}, {4{8'hFF}}};
  localparam logic [7:0] REG_RESET = 8'h00;
  // high pass shifts at the highest sample rate
  localparam int HPF_K_1HZ = 15;
  localparam int HPF_K_4HZ = 13;
  localparam int HPF_K_8HZ = 12;
  // volume fine steps of 0.375 dB in Q1.15, index 15 first
  localparam logic [15:0][15:0] VOL_COEF = {
    16'h42FC, 16'h45F0, 16'h4906, 16'h4C3F, 16'h4F9B, 16'h531B,
    16'h56CC, 16'h5A9E, 16'h5E9E, 16'h62CA, 16'h672A, 16'h6BC7,
    16'h70AB, 16'h7583, 16'h7A9A, 16'h8000};
endpackage

// ===== tb/aipc_mic_model.sv
// behavioural pair of density-stream microphones sharing one data pin
module aipc_mic_model (
  // device clock and the bit level each mic sends
  input  wire logic clkIn,
  input  wire logic leftBit,
  input  wire logic rightBit,
  // shared data pin
  output logic      dataOut
);
  timeunit 1ns;
  timeprecision 1ns;

  // pin starts low; a real mic would float, but the host samples later
  initial dataOut = 1'b0;

  // left mic drives while the clock is high, so the host sees it stable
  // at the falling edge; clocked only by the device pin
  always @(posedge clkIn) begin
    dataOut <= leftBit;
  end

  // right mic takes the low half, seen at the rising edge
  always @(negedge clkIn) begin
    dataOut <= rightBit;
  end
endmodule

// ===== tb/tb_audio_input_path_control.sv
// self-checking bench for the audio input path control block
module tb_audio_input_path_control import aipc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  // stimulus and observed signals
  logic             mclk = 1'b0;
  logic             reset = 1'b1;
  logic [7:0]       regAddr = 8'h00;
  logic [7:0]       regWdata = 8'h00;
  logic             regWr = 1'b0;
  logic             regRd = 1'b0;
  logic [7:0]       regRdata;
  logic [3:0][23:0] adcSample = '0;
  logic [3:0]       adcValid = 4'h0;
  logic [1:0][23:0] asrcSample = '0;
  logic             asrcValid = 1'b0;
  logic             micA;
  logic             micB;
  logic [3:0]       micBits = 4'h9;  // [0] a left [1] a right [2] b left [3] b right
  logic             clock_output_pin;
  logic             serBit = 1'b0;
  logic             denBit = 1'b0;
  logic             sharedPin;
  logic [1:0]       hpEnable = 2'b00;
  logic [5:0]       prechargeOn;
  logic [3:0]       gaEn;
  logic [3:0]       gaBoost;
  logic [3:0][5:0]  gaGain;
  logic [1:0]       biasEn;
  logic [1:0]       biasHi;
  logic             rate96;
  logic [3:0][23:0] coreSample;
  logic [3:0]       coreValid;
  // expected results, oldest first
  logic [23:0]      expQ [4][$];
  logic [7:0]       rdQ [$];
  logic             rdDly = 1'b0;
  logic [31:0]      seed = 32'h2BB9;
  int               errCount = 0;
  int               checkCount = 0;
  // mapped offsets in register file slot order
  localparam logic [7:0] ADDR [16] = '{OFF_CTL0, 8'h1C, 8'h1D, OFF_CTL3,
    OFF_VOL0, 8'h20, 8'h21, OFF_VOL3, OFF_GAIN0, 8'h24, 8'h25, OFF_GAIN3,
    OFF_POP, OFF_BIAS, OFF_PINA, OFF_PINB};

  always #10 mclk = ~mclk;

  // density source toggles so the shared pin shows which input it carries
  always @(posedge mclk) denBit <= !denBit;

  aipc_input_path #(.CLK_HALF(4), .DECIM(64)) DUT (
    .mclk(mclk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .adcSample(adcSample), .adcValid(adcValid), .asrcSample(asrcSample),
    .asrcValid(asrcValid), .micPairAPin(micA), .micPairBPin(micB),
    .clockOutputPin(clock_output_pin), .serialOutDataFirst(serBit),
    .densityStreamBit(denBit), .sharedOutPin(sharedPin),
    .hpEnable(hpEnable), .prechargeOn(prechargeOn), .gainAmpEnable(gaEn),
    .gainAmpBoost(gaBoost), .gainAmpGain(gaGain), .micBiasEnable(biasEn),
    .micBiasHigh(biasHi), .rate96(rate96), .coreSample(coreSample),
    .coreValid(coreValid));

  // pair a: left all ones, right all zeros; pair b the other way round
  aipc_mic_model micModelA (.clkIn(clock_output_pin), .leftBit(micBits[0]),
    .rightBit(micBits[1]), .dataOut(micA));
  aipc_mic_model micModelB (.clkIn(clock_output_pin), .leftBit(micBits[2]),
    .rightBit(micBits[3]), .dataOut(micB));

  // xorshift source of random stimulus
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  // sign reversal that saturates instead of wrapping
  function automatic logic [23:0] neg(input logic [23:0] x);
    return (x == 24'h800000) ? 24'h7FFFFF : -x;
  endfunction

  // compare one value and count it
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errCount++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // final verdict; leftover expectations mean missing samples
  task automatic testDone();
    for (int c = 0; c < 4; c++) begin
      if (expQ[c].size() != 0) errCount++;
    end
    $display("checks %0d errors %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // one-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask

  // one-cycle register read; the monitor checks the answer
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    rdQ.push_back(e);
    @(posedge mclk);
    regRd <= 1'b0;
  endtask

  // one converter sample; on says whether a core pulse is due
  task automatic smp(input int c, input logic [23:0] x,
                     input logic [23:0] e, input logic on);
    @(posedge mclk);
    adcSample[c] <= x;
    adcValid[c] <= 1'b1;
    if (on) expQ[c].push_back(e);
    @(posedge mclk);
    adcValid[c] <= 1'b0;
  endtask

  // wait for a channel's notes to be used up, then unroute it
  task automatic drain(input int c);
    for (int n = 0; n < 2000; n++) begin
      if (expQ[c].size() == 0) break;
      @(posedge mclk);
    end
    wr(OFF_CTL0 + 8'(c), 8'h00);
  endtask

  // set pair a to mics, let windows settle, then take two samples each
  task automatic micRun(input logic [7:0] ctlv, input logic [7:0] pinv,
                        input logic [23:0] e0, input logic [23:0] e1);
    wr(OFF_PINA, pinv);
    wr(OFF_CTL0 + 8'h2, ctlv);
    repeat (600) @(posedge mclk);
    repeat (2) expQ[0].push_back(e0);
    repeat (2) expQ[1].push_back(e1);
    wr(OFF_CTL0, 8'h10);
    wr(OFF_CTL0 + 8'h1, 8'h10);
    drain(0);
    drain(1);
  endtask

  // read data stand the cycle after the strobe
  always @(posedge mclk) rdDly <= regRd;

  // monitor: each result takes the oldest note of its queue
  always @(negedge mclk) begin
    if (rdDly) check(24'(regRdata), rdQ.pop_front());
    for (int c = 0; c < 4; c++) begin
      if (coreValid[c] === 1'b1) begin
        if (expQ[c].size() == 0) begin
          errCount++;
          $display("[FAIL] %0t stray sample on channel %0d", $time, c);
        end else begin
          check(coreSample[c], expQ[c].pop_front());
        end
      end
    end
  end

  // watchdog, far beyond the expected run of a few thousand cycles
  initial begin
    #400000;
    errCount++;
    $display("[FAIL] %0t watchdog expired", $time);
    testDone();
  end

  // main sequence
  initial begin
    logic [7:0]  v;
    logic [23:0] x;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
    check(24'(prechargeOn), 24'h3F);
    // reset values, write and read back, unmapped place
    for (int i = 0; i < 16; i++) rd(ADDR[i], 8'h00);
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      // route stays off so no stray samples appear meanwhile
      v = seed[7:0] & ((i < 4) ? 8'hEF : 8'hFF);
      wr(ADDR[i], v);
      rd(ADDR[i], v & REG_MASK[i]);
    end
    wr(8'h27, 8'hA5);
    rd(8'h27, 8'h00);
    for (int i = 0; i < 16; i++) wr(ADDR[i], 8'h00);
    // analog controls, precharge and rate
    wr(OFF_BIAS, 8'h0B);
    wr(OFF_GAIN0 + 8'h1, 8'hC5);
    wr(OFF_GAIN0, 8'h80);
    wr(OFF_POP, 8'h02);
    wr(OFF_CTL0, 8'h80);
    hpEnable <= 2'b01;
    serBit <= 1'b1;
    wr(OFF_CTL0 + 8'h1, 8'h80);
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    check(24'({biasHi, biasEn}), 24'hD);
    check(24'(gaEn), 24'h3);
    check(24'({gaBoost, gaGain[1]}), 24'(10'h085));
    check(24'(prechargeOn), 24'h2C);
    check(24'(rate96), 24'h1);
    check(24'(sharedPin), 24'(!denBit));
    wr(OFF_CTL0 + 8'h1, 8'h00);
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    check(24'(sharedPin), 24'h1);
    // converter samples through sign, clip, volume, mute and routing
    for (int c = 0; c < 4; c++) wr(OFF_CTL0 + 8'(c), 8'h10);
    wr(OFF_GAIN0 + 8'h1, 8'h00);
    for (int c = 1; c < 4; c++) begin
      seed = xs(seed);
      smp(c, seed[23:0], seed[23:0], 1'b1);
    end
    seed = xs(seed);
    smp(0, seed[23:0], neg(seed[23:0]), 1'b1);
    smp(0, 24'h800000, 24'h7FFFFF, 1'b1);
    wr(OFF_VOL0 + 8'h1, 8'h20);
    x = seed[23:0] & 24'hFFFFFC;
    smp(1, x, {{2{x[23]}}, x[23:2]}, 1'b1);
    wr(OFF_CTL0 + 8'h2, 8'h11);
    smp(2, x, 24'h000000, 1'b1);
    wr(OFF_CTL3, 8'h00);
    smp(3, x, x, 1'b0);
    // rate converter pair feeds channels 0 and 1
    wr(OFF_GAIN0, 8'h00);
    wr(OFF_VOL0 + 8'h1, 8'h00);
    wr(OFF_CTL0, 8'h30);
    wr(OFF_CTL0 + 8'h1, 8'h30);
    seed = xs(seed);
    @(posedge mclk);
    asrcSample <= {seed[31:8], seed[23:0]};
    asrcValid <= 1'b1;
    expQ[0].push_back(seed[23:0]);
    expQ[1].push_back(seed[31:8]);
    @(posedge mclk);
    asrcValid <= 1'b0;
    for (int c = 0; c < 3; c++) wr(OFF_CTL0 + 8'(c), 8'h00);
    // microphones on pair a: plain, then swapped with odd sign reversed
    micRun(8'h40, 8'h01, 24'h7FFFFF, 24'h800000);
    micRun(8'hC0, 8'h21, 24'h800000, 24'h800000);
    // pair b still takes its converters while pair a listens to mics
    wr(OFF_CTL0 + 8'h2, 8'hD0);
    seed = xs(seed);
    smp(2, seed[23:0], seed[23:0], 1'b1);
    repeat (4) @(posedge mclk);
    testDone();
  end
endmodule
